// ---- rtl/reig_defs.svh ----
// register offsets, field positions and reset values of the enable bank
// assumes byte-wide register port with 8-bit addresses
`ifndef REIG_DEFS_SVH
`define REIG_DEFS_SVH
`define REIG_OFS_IRQ_MASTER_LOW 8'h60
`define REIG_OFS_RX_EN_UPPER    8'h88
`define REIG_FIELD_MSB          5
`define REIG_FIELD_W            6
`define REIG_RST_IRQ_MASTER     6'h00
`define REIG_RST_RX_EN          6'h00
`endif

// ---- rtl/reig_pkg.sv ----
// types shared by the enable bank modules
// assumes nothing beyond a synthesis tool with package support
package reig_pkg;
  typedef logic [7:0] reig_byte_t;
  typedef logic [5:0] reig_chan_t;
  typedef enum logic [1:0]
  {
    REIG_SEL_NONE = 2'b00,
    REIG_SEL_IRQ  = 2'b01,
    REIG_SEL_RX   = 2'b10
  } reig_sel_t;
endpackage

// ---- rtl/reig_gate_if.sv ----
// carrier between the bank top and the interrupt gate
// assumes one clock domain on both sides
interface reig_gate_if #(parameter int NCH = 6);
  logic [NCH-1:0] master_en;
  logic [NCH-1:0] chan_irq;
  logic [NCH-1:0] src_en;
  logic           irq_any;
  modport bank (output master_en, output chan_irq, output src_en, input irq_any);
  modport gate (input master_en, input chan_irq, input src_en, output irq_any);
endinterface

// ---- rtl/reig_irq_gate.sv ----
// channel-level interrupt gating: one combinational OR of gated requests
// assumes inputs are synchronous to the bank clock
module reig_irq_gate #(parameter int NCH = 6)
(
  reig_gate_if.gate g
);
  // a gate with no channels has nothing to combine, so refuse it early
  if (NCH < 1)
  begin : g_bad_nch
    $error("NCH must be at least one");
  end

  // =====================================================
  // gating
  // source enable, then master enable, then OR of all channels
  assign g.irq_any = |(g.chan_irq & g.src_en & g.master_en);
endmodule

// ---- rtl/reig_rx_enable_irq_gating.sv ----
// receiver enables for channels 6..11 and channel interrupt master enables 0..5
// assumes a synchronous byte-wide host port; channel events synchronous to clk_sys
// and a host that keeps its strobes low between accesses
`include "reig_defs.svh"
module reig_rx_enable_irq_gating #(parameter int NCH = 6)
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  input  wire logic [7:0]     host_addr,
  input  wire logic [7:0]     host_wdata,
  input  wire logic           host_wr,
  input  wire logic           host_rd,
  output logic      [7:0]     host_rdata,
  input  wire logic [NCH-1:0] chan_irq,
  input  wire logic [NCH-1:0] source_irq_enable_reg,
  output logic                host_irq,
  output logic      [NCH-1:0] receiver_on,
  output logic      [NCH-1:0] rx_line_hiz
);
  // =====================================================
  // parameter check
  // the register fields are six bits wide, so only six channels map onto them
  if (NCH != `REIG_FIELD_W)
  begin : g_bad_nch
    $error("NCH must equal the six-bit field width");
  end

  // =====================================================
  // registers
  // both reset to zero, so every receiver starts parked in high-z
  reig_pkg::reig_chan_t channel_irq_master_enable_low;
  reig_pkg::reig_chan_t receiver_enable_upper;
  reig_pkg::reig_sel_t  sel;
  reig_gate_if #(.NCH(NCH)) gif ();

  // address decode
  // all eight address bits are compared, so no alias of either offset hits a register
  always_comb
  begin
    if (host_addr == `REIG_OFS_IRQ_MASTER_LOW)
      sel = reig_pkg::REIG_SEL_IRQ;
    else if (host_addr == `REIG_OFS_RX_EN_UPPER)
      sel = reig_pkg::REIG_SEL_RX;
    else
      sel = reig_pkg::REIG_SEL_NONE;
  end

  // master enable write; bits 7,6 dropped
  // only six bits are stored, so reserved bits can never come back on a read
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      channel_irq_master_enable_low <= `REIG_RST_IRQ_MASTER;
    else if (clk_en && host_wr && sel == reig_pkg::REIG_SEL_IRQ)
      channel_irq_master_enable_low <= host_wdata[`REIG_FIELD_MSB:0];
  end

  // receiver enable write
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      receiver_enable_upper <= `REIG_RST_RX_EN;
    else if (clk_en && host_wr && sel == reig_pkg::REIG_SEL_RX)
      receiver_enable_upper <= host_wdata[`REIG_FIELD_MSB:0];
  end

  // read data; unmapped and reserved bits return zero
  // registered read costs a cycle but keeps the data pins straight off flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      host_rdata <= 8'h00;
    else if (clk_en && host_rd)
    begin
      case (sel)
        reig_pkg::REIG_SEL_IRQ: host_rdata <= {2'b00, channel_irq_master_enable_low};
        reig_pkg::REIG_SEL_RX:  host_rdata <= {2'b00, receiver_enable_upper};
        default:                host_rdata <= 8'h00;
      endcase
    end
  end

  // =====================================================
  // receiver control, registered so outputs come from flops
  // limitation: a new enable reaches the pins two edges after its write
  // high-z is its own flop rather than an inverter, so both pins switch together
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      receiver_on <= '0;
      rx_line_hiz <= '1;
    end
    else if (clk_en)
    begin
      receiver_on <= receiver_enable_upper;
      rx_line_hiz <= ~receiver_enable_upper;
    end
  end

  // =====================================================
  // interrupt gating; an unset source enable keeps the channel quiet
  // level only: nothing is latched here, the channel must hold its request
  assign gif.master_en = channel_irq_master_enable_low;
  assign gif.chan_irq  = chan_irq;
  assign gif.src_en    = source_irq_enable_reg;

  reig_irq_gate #(.NCH(NCH)) u_gate (.g(gif.gate));

  // one flop of latency on the pin
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      host_irq <= 1'b0;
    else if (clk_en)
      host_irq <= gif.irq_any;
  end

  // =====================================================
  // checks
  // the first group restates pin and write behaviour cycle by cycle
  a_rx_hiz_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (rx_line_hiz == ~$past(receiver_enable_upper)))
    else $error("line high-z does not follow cleared enable");
  a_rx_on_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (receiver_on == $past(receiver_enable_upper)))
    else $error("receiver on does not follow enable");
  a_rx_write_takes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && host_wr && host_addr == 8'h88) |=> receiver_enable_upper == $past(host_wdata[5:0]))
    else $error("rx enable write lost");
  a_irq_write_takes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && host_wr && host_addr == 8'h60)
      |=> channel_irq_master_enable_low == $past(host_wdata[5:0]))
    else $error("master enable write lost");
  a_irq_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && channel_irq_master_enable_low == 6'h00) |=> !host_irq)
    else $error("interrupt passed with all masters cleared");
  a_irq_passes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && |(chan_irq & source_irq_enable_reg & channel_irq_master_enable_low))
      |=> host_irq)
    else $error("enabled interrupt did not reach host pin");
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    host_rdata[7:6] == 2'b00)
    else $error("reserved bits read nonzero");
  a_no_src_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && source_irq_enable_reg == 6'h00) |=> !host_irq)
    else $error("interrupt without source enable");

  // =====================================================
  // reset checks
  // no disable here, so the reset cycles themselves are watched
  a_reset_line_hiz: assert property (@(posedge clk_sys)
    !rst_n |=> (rx_line_hiz == 6'h3f && receiver_on == 6'h00))
    else $error("receivers not parked off after reset");
  a_reset_irq_quiet: assert property (@(posedge clk_sys)
    !rst_n |=> (!host_irq && channel_irq_master_enable_low == 6'h00))
    else $error("host interrupt or master enable set after reset");
  a_reset_rdata_zero: assert property (@(posedge clk_sys)
    !rst_n |=> host_rdata == 8'h00)
    else $error("read data not cleared by reset");

  // =====================================================
  // clock enable checks
  // a low enable must leave every register and pin where it stood
  // it is the only way a host can hold the bank still, so it must be exact
  a_freeze_rx_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> ($stable(receiver_enable_upper) && $stable(receiver_on)
      && $stable(rx_line_hiz)))
    else $error("receiver state moved with clock enable low");
  a_freeze_irq_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> ($stable(channel_irq_master_enable_low) && $stable(host_irq)))
    else $error("interrupt state moved with clock enable low");
  a_freeze_rdata: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> $stable(host_rdata))
    else $error("read data moved with clock enable low");

  // =====================================================
  // read path and write decode checks
  // read data shows the register as it stood at the read edge
  a_read_irq_reg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && host_rd && host_addr == `REIG_OFS_IRQ_MASTER_LOW)
      |=> host_rdata == {2'b00, $past(channel_irq_master_enable_low)})
    else $error("master enable readback wrong");
  a_read_rx_reg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && host_rd && host_addr == `REIG_OFS_RX_EN_UPPER)
      |=> host_rdata == {2'b00, $past(receiver_enable_upper)})
    else $error("rx enable readback wrong");
  // unmapped space must read as zero
  a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && host_rd && host_addr != `REIG_OFS_IRQ_MASTER_LOW
      && host_addr != `REIG_OFS_RX_EN_UPPER) |=> host_rdata == 8'h00)
    else $error("unmapped read returned data");
  // read data stands until the next read
  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(clk_en && host_rd) |=> $stable(host_rdata))
    else $error("read data moved without a read");
  // a write to another address, or none, must leave a register alone
  a_rx_write_other: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(clk_en && host_wr && host_addr == `REIG_OFS_RX_EN_UPPER)
      |=> $stable(receiver_enable_upper))
    else $error("rx enable changed without a write to it");
  a_irq_write_other: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(clk_en && host_wr && host_addr == `REIG_OFS_IRQ_MASTER_LOW)
      |=> $stable(channel_irq_master_enable_low))
    else $error("master enable changed without a write to it");
  // a written enable reaches the receiver pin two enabled edges later
  a_rx_pins_settle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && host_wr && host_addr == `REIG_OFS_RX_EN_UPPER) ##1 clk_en
      |=> receiver_on == $past(host_wdata[5:0], 2))
    else $error("receiver on not set two edges after write");

  // =====================================================
  // interrupt and pin checks
  // per channel: no request that lacks its master bit may lift the pin
  a_irq_chan_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && ((chan_irq & source_irq_enable_reg & channel_irq_master_enable_low) == 6'h00))
      |=> !host_irq)
    else $error("interrupt passed from a channel without its master bit");
  // the two receiver pins must never disagree
  a_hiz_inverse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_line_hiz == ~receiver_on)
    else $error("line high-z and receiver on disagree");
endmodule

// ---- bench/reig_host_model.sv ----
// ==========
// host processor model driving the byte-wide register port
// assumes the bank samples strobes on the rising edge of clk_sys
module reig_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] host_rdata,
  output logic      [7:0] host_addr,
  output logic      [7:0] host_wdata,
  output logic            host_wr,
  output logic            host_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port: strobes low, address parked off the map
  initial
  begin
    host_addr = 8'hff;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // one-cycle write strobe; released data shows its inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clk_sys);
    #1 host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  // one-cycle read strobe; data taken a cycle later, it holds
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 host_addr = a;
    host_rd = 1'b1;
    @(posedge clk_sys);
    #1 host_rd = 1'b0;
    @(posedge clk_sys);
    #1 d = host_rdata;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// ==========
// random bench for the enable bank; host model drives the port
// assumes a 125 MHz clk_sys and synchronous active-low reset
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, clk_en, host_wr, host_rd, host_irq, q;
  logic [7:0] host_addr, host_wdata, host_rdata, d, a, e;
  logic [5:0] chan_irq, src, receiver_on, rx_line_hiz, m, rx;
  int n_errors, n_compared, seed;
  // free-running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  reig_host_model u_host (.clk_sys(clk_sys), .host_rdata(host_rdata), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd));
  reig_rx_enable_irq_gating #(.NCH(6)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .chan_irq(chan_irq), .source_irq_enable_reg(src),
    .host_irq(host_irq), .receiver_on(receiver_on), .rx_line_hiz(rx_line_hiz));
  // one compare task per kind of result; !== lets no unknown slip through
  task automatic chk_rdata(input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH host_rdata exp %h got %h", x, g);
    end
  endtask
  task automatic chk_rx(input string nm, input logic [5:0] x, input logic [5:0] g);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic chk_irq(input logic x, input logic g);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH host_irq exp %h got %h", x, g);
    end
  endtask
  // every pin and the read data at their reset values
  task automatic chk_reset;
    chk_rx("rx_line_hiz", 6'h3f, rx_line_hiz);
    chk_rx("receiver_on", 6'h00, receiver_on);
    chk_irq(1'b0, host_irq);
    chk_rdata(8'h00, host_rdata);
  endtask
  // only channels with master, source enable and request raise the pin
  function automatic logic irq_exp(input logic [5:0] mm, c, s);
    return |(mm & c & s);
  endfunction
  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // reset, then random writes and reads with the map edges mixed in
  initial
  begin
    seed = 21;
    rst_n = 1'b0;
    clk_en = 1'b1;
    chan_irq = 6'h00;
    src = 6'h00;
    m = 6'h00;
    rx = 6'h00;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk_reset();
    for (int i = 0; i < 40; i++)
    begin
      a = 8'($random(seed));
      if (a == 8'h60 || a == 8'h88)
        a = a ^ 8'h01;
      if (i % 3 == 0)
        a = 8'h60;
      if (i % 3 == 1)
        a = 8'h88;
      d = 8'($random(seed));
      u_host.wr(a, d);
      e = (a == 8'h60 || a == 8'h88) ? (d & 8'h3f) : 8'h00;
      if (a == 8'h60)
        m = d[5:0];
      if (a == 8'h88)
        rx = d[5:0];
      u_host.rd(a, d);
      chk_rdata(e, d);
      chk_rx("receiver_on", rx, receiver_on);
      chk_rx("rx_line_hiz", ~rx, rx_line_hiz);
      src = 6'($random(seed));
      chan_irq = 6'($random(seed));
      repeat (2) @(posedge clk_sys);
      #1 chk_irq(irq_exp(m, chan_irq, src), host_irq);
    end
    // clock enable low: writes are dropped and host_irq and receiver_on hold their state
    q = irq_exp(m, chan_irq, src);
    clk_en = 1'b0;
    u_host.wr(8'h88, {2'b00, ~rx});
    u_host.wr(8'h60, {2'b00, ~m});
    src = ~src;
    chan_irq = ~chan_irq;
    repeat (2) @(posedge clk_sys);
    #1 chk_irq(q, host_irq);
    chk_rx("receiver_on", rx, receiver_on);
    clk_en = 1'b1;
    u_host.rd(8'h88, d);
    chk_rdata({2'b00, rx}, d);
    u_host.rd(8'h60, d);
    chk_rdata({2'b00, m}, d);
    chk_irq(irq_exp(m, chan_irq, src), host_irq);
    // reset in mid-run: both registers and all pins return to reset state
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    m = 6'h00;
    rx = 6'h00;
    chk_reset();
    u_host.rd(8'h60, d);
    chk_rdata({2'b00, m}, d);
    finish_test();
  end
endmodule
